// ==== rtl/aocfr_pkg.sv ====
package aocfr_pkg;

  localparam logic [7:0] OFS_OUTPUT_STAGE = 8'h06;
  localparam logic [7:0] OFS_RESERVED     = 8'h07;
  localparam logic [7:0] OFS_FAULT        = 8'h08;

  localparam logic [7:0] RST_OUTPUT_STAGE = 8'h51;
  localparam logic [1:0] RST_TRIP_LEVEL   = 2'h0;

  localparam int POS_BRIDGE     = 7;
  localparam int POS_RATE_HI    = 6;
  localparam int POS_RATE_LO    = 4;
  localparam int POS_GAIN_HI    = 3;
  localparam int POS_GAIN_LO    = 2;
  localparam int POS_SOURCE     = 1;
  localparam int POS_TRIP_HI    = 5;
  localparam int POS_TRIP_LO    = 4;

  localparam logic [1:0] GAIN_RESERVED = 2'h3;

  // Arbitrary default control-port address
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2a;

  // Single-speed multiples of the frame clock
  localparam logic [4:0] RATE_X6  = 5'h06;
  localparam logic [4:0] RATE_X8  = 5'h08;
  localparam logic [4:0] RATE_X10 = 5'h0a;
  localparam logic [4:0] RATE_X12 = 5'h0c;
  localparam logic [4:0] RATE_X14 = 5'h0e;
  localparam logic [4:0] RATE_X16 = 5'h10;
  localparam logic [4:0] RATE_X20 = 5'h14;
  localparam logic [4:0] RATE_X24 = 5'h18;

  localparam logic [6:0] TRIP_PCT_100 = 7'h64;
  localparam logic [6:0] TRIP_PCT_75  = 7'h4b;
  localparam logic [6:0] TRIP_PCT_50  = 7'h32;
  localparam logic [6:0] TRIP_PCT_25  = 7'h19;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WRITE, ST_WRITE_ACK, ST_READ, ST_READ_ACK
  } aocfr_i2c_state_t;

  function automatic logic [4:0] aocfr_rate_mult(input logic [2:0] code,
                                                 input logic       double_speed);
    logic [4:0] m;
    m = RATE_X16;
    unique case (code)
      3'h0: m = RATE_X6;
      3'h1: m = RATE_X8;
      3'h2: m = RATE_X10;
      3'h3: m = RATE_X12;
      3'h4: m = RATE_X14;
      3'h5: m = RATE_X16;
      3'h6: m = RATE_X20;
      3'h7: m = RATE_X24;
    endcase
    return double_speed ? (m >> 1) : m;
  endfunction : aocfr_rate_mult

  function automatic logic [6:0] aocfr_trip_pct(input logic [1:0] code);
    logic [6:0] p;
    p = TRIP_PCT_100;
    unique case (code)
      2'h0: p = TRIP_PCT_100;
      2'h1: p = TRIP_PCT_75;
      2'h2: p = TRIP_PCT_50;
      2'h3: p = TRIP_PCT_25;
    endcase
    return p;
  endfunction : aocfr_trip_pct

endpackage : aocfr_pkg

// ==== rtl/aocfr_reg_if.sv ====
`timescale 1ns/10ps
interface aocfr_reg_if;
  logic       wr_stb;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport port_side (output wr_stb, output addr, output wdata, input rdata);
  modport bank_side (input wr_stb, input addr, input wdata, output rdata);
endinterface : aocfr_reg_if

// ==== rtl/aocfr_i2c_slave.sv ====
`timescale 1ns/10ps
module aocfr_i2c_slave #(
  parameter logic [6:0] DEV_ADDR = aocfr_pkg::DEV_ADDR_DEFAULT
) (
  input  wire logic           clk_sys,
  input  wire logic           arst_n,
  input  wire logic           scl_in,
  input  wire logic           sda_in,
  output logic                sda_out,
  output logic                sda_oe_n,
  aocfr_reg_if.port_side      bus
);

  logic [2:0] scl_sync_reg;
  logic [2:0] sda_sync_reg;
  logic       scl_reg;
  logic       sda_reg;
  logic       scl_next;
  logic       sda_next;
  aocfr_pkg::aocfr_i2c_state_t state_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic [3:0] cnt_reg;
  logic [7:0] ptr_reg;
  logic       first_reg;
  logic       rw_reg;
  logic       drive_low_reg;
  logic       acked_reg;
  logic       wr_stb_reg;
  logic [7:0] wdata_reg;

  // Pins change only once stages two and three agree
  assign scl_next = (scl_sync_reg[1] == scl_sync_reg[2]) ? scl_sync_reg[2] : scl_reg;
  assign sda_next = (sda_sync_reg[1] == sda_sync_reg[2]) ? sda_sync_reg[2] : sda_reg;

  wire scl_rise   = scl_next & ~scl_reg;
  wire scl_fall   = ~scl_next & scl_reg;
  wire start_cond = scl_reg & scl_next & sda_reg & ~sda_next;
  wire stop_cond  = scl_reg & scl_next & ~sda_reg & sda_next;
  wire byte_done  = scl_fall & (cnt_reg == 4'h8);
  wire addr_match = (shift_reg[7:1] == DEV_ADDR);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      scl_reg      <= 1'b1;
      sda_reg      <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
      scl_reg      <= scl_next;
      sda_reg      <= sda_next;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg     <= aocfr_pkg::ST_IDLE;
      shift_reg     <= 8'h00;
      tx_reg        <= 8'h00;
      cnt_reg       <= 4'h0;
      ptr_reg       <= 8'h00;
      first_reg     <= 1'b0;
      rw_reg        <= 1'b0;
      drive_low_reg <= 1'b0;
      acked_reg     <= 1'b0;
      wr_stb_reg    <= 1'b0;
      wdata_reg     <= 8'h00;
    end else begin
      wr_stb_reg <= 1'b0;
      if (start_cond) begin
        state_reg     <= aocfr_pkg::ST_ADDR;
        cnt_reg       <= 4'h0;
        drive_low_reg <= 1'b0;
      end else if (stop_cond) begin
        state_reg     <= aocfr_pkg::ST_IDLE;
        drive_low_reg <= 1'b0;
      end else begin
        unique case (state_reg)
          aocfr_pkg::ST_IDLE: begin
          end
          aocfr_pkg::ST_ADDR, aocfr_pkg::ST_WRITE: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_next};
              cnt_reg   <= cnt_reg + 4'h1;
            end else if (byte_done) begin
              if (state_reg == aocfr_pkg::ST_ADDR) begin
                state_reg     <= addr_match ? aocfr_pkg::ST_ADDR_ACK : aocfr_pkg::ST_IDLE;
                drive_low_reg <= addr_match;
                rw_reg        <= shift_reg[0];
                first_reg     <= 1'b1;
              end else begin
                state_reg     <= aocfr_pkg::ST_WRITE_ACK;
                drive_low_reg <= 1'b1;
                first_reg     <= 1'b0;
                if (first_reg) begin
                  ptr_reg <= shift_reg;
                end else begin
                  wr_stb_reg <= 1'b1;
                  wdata_reg  <= shift_reg;
                end
              end
            end
          end
          aocfr_pkg::ST_WRITE_ACK: begin
            // Step only after the strobe has used the old pointer
            if (wr_stb_reg) begin
              ptr_reg <= ptr_reg + 8'h01;
            end
            if (scl_fall) begin
              state_reg     <= aocfr_pkg::ST_WRITE;
              drive_low_reg <= 1'b0;
              cnt_reg       <= 4'h0;
            end
          end
          aocfr_pkg::ST_ADDR_ACK: begin
            if (scl_fall) begin
              cnt_reg <= rw_reg ? 4'h1 : 4'h0;
              if (rw_reg) begin
                state_reg     <= aocfr_pkg::ST_READ;
                drive_low_reg <= ~bus.rdata[7];
                tx_reg        <= {bus.rdata[6:0], 1'b0};
              end else begin
                state_reg     <= aocfr_pkg::ST_WRITE;
                drive_low_reg <= 1'b0;
              end
            end
          end
          aocfr_pkg::ST_READ: begin
            if (scl_fall) begin
              if (cnt_reg == 4'h8) begin
                state_reg     <= aocfr_pkg::ST_READ_ACK;
                drive_low_reg <= 1'b0;
                ptr_reg       <= ptr_reg + 8'h01;
              end else begin
                drive_low_reg <= ~tx_reg[7];
                tx_reg        <= {tx_reg[6:0], 1'b0};
                cnt_reg       <= cnt_reg + 4'h1;
              end
            end
          end
          aocfr_pkg::ST_READ_ACK: begin
            if (scl_rise) begin
              acked_reg <= ~sda_next;
            end else if (scl_fall) begin
              // A missing acknowledge ends the read; wait for stop
              state_reg     <= acked_reg ? aocfr_pkg::ST_READ : aocfr_pkg::ST_IDLE;
              drive_low_reg <= acked_reg & ~bus.rdata[7];
              tx_reg        <= {bus.rdata[6:0], 1'b0};
              cnt_reg       <= 4'h1;
            end
          end
          default: begin
            state_reg <= aocfr_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  assign sda_out    = 1'b0;
  assign sda_oe_n   = ~drive_low_reg;
  assign bus.wr_stb = wr_stb_reg;
  assign bus.addr   = ptr_reg;
  assign bus.wdata  = wdata_reg;

endmodule : aocfr_i2c_slave

// ==== rtl/aocfr_top.sv ====
`timescale 1ns/10ps
module aocfr_top #(
  parameter logic [6:0] DEV_ADDR = aocfr_pkg::DEV_ADDR_DEFAULT
) (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  input  wire logic        double_speed_mode,
  input  wire logic [23:0] left_sample,
  input  wire logic [23:0] right_sample,
  input  wire logic        sample_valid,
  input  wire logic        clock_error_det,
  input  wire logic        overcurrent_det,
  input  wire logic        output_offset_det,
  input  wire logic        overtemp_det,
  input  wire logic        amp_shutdown_input_n,
  output logic             parallel_bridge_select,
  output logic [4:0]       switch_rate_mult,
  output logic [1:0]       analog_gain_sel,
  output logic [1:0]       overcurrent_trip_level,
  output logic [6:0]       trip_level_pct,
  output logic             amp_halt,
  output logic [23:0]      amp_a_sample,
  output logic [23:0]      amp_b_sample,
  output logic             amp_sample_valid
);

  aocfr_reg_if bus ();

  aocfr_i2c_slave #(
    .DEV_ADDR (DEV_ADDR)
  ) u_port (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .sda_out  (sda_out),
    .sda_oe_n (sda_oe_n),
    .bus      (bus.port_side)
  );

  logic [7:0]  stage_reg;
  logic [7:0]  stage_next;
  logic [1:0]  trip_reg;
  logic [2:0]  sd_sync_reg;
  logic        sd_n_reg;
  logic        sd_n_next;
  logic        clk_err_reg;
  logic        oc_flag_reg;
  logic        dc_flag_reg;
  logic        ot_flag_reg;
  logic [4:0]  rate_reg;
  logic [6:0]  pct_reg;
  logic        halt_reg;
  logic [23:0] a_reg;
  logic [23:0] b_reg;
  logic        valid_reg;

  wire wr_stage = bus.wr_stb & (bus.addr == aocfr_pkg::OFS_OUTPUT_STAGE);
  wire wr_fault = bus.wr_stb & (bus.addr == aocfr_pkg::OFS_FAULT);

  // A reserved gain code is refused; the previous gain stays in force
  wire gain_bad = (bus.wdata[aocfr_pkg::POS_GAIN_HI:aocfr_pkg::POS_GAIN_LO]
                   == aocfr_pkg::GAIN_RESERVED);
  assign stage_next = gain_bad ?
      {bus.wdata[7:4], stage_reg[aocfr_pkg::POS_GAIN_HI:aocfr_pkg::POS_GAIN_LO],
       bus.wdata[1:0]} : bus.wdata;

  wire [7:0] fault_rd = {2'h0, trip_reg, clk_err_reg, oc_flag_reg, dc_flag_reg,
                         ot_flag_reg};

  // Reserved slot and unused offsets read as zero and drop writes
  assign bus.rdata = (bus.addr == aocfr_pkg::OFS_OUTPUT_STAGE) ? stage_reg :
                     (bus.addr == aocfr_pkg::OFS_FAULT)        ? fault_rd  :
                     8'h00;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stage_reg <= aocfr_pkg::RST_OUTPUT_STAGE;
      trip_reg  <= aocfr_pkg::RST_TRIP_LEVEL;
    end else begin
      if (wr_stage) begin
        stage_reg <= stage_next;
      end
      if (wr_fault) begin
        trip_reg <= bus.wdata[aocfr_pkg::POS_TRIP_HI:aocfr_pkg::POS_TRIP_LO];
      end
    end
  end

  // Shutdown pin crosses in through three stages
  assign sd_n_next = (sd_sync_reg[1] == sd_sync_reg[2]) ? sd_sync_reg[2] : sd_n_reg;
  wire sd_active = ~sd_n_next;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sd_sync_reg <= 3'h0;
      sd_n_reg    <= 1'b0;
    end else begin
      sd_sync_reg <= {sd_sync_reg[1:0], amp_shutdown_input_n};
      sd_n_reg    <= sd_n_next;
    end
  end

  // Detection beats the shutdown clear, so no fault is lost
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      clk_err_reg <= 1'b0;
      oc_flag_reg <= 1'b0;
      dc_flag_reg <= 1'b0;
      ot_flag_reg <= 1'b0;
    end else begin
      clk_err_reg <= clock_error_det;
      oc_flag_reg <= overcurrent_det | (oc_flag_reg & ~sd_active);
      dc_flag_reg <= output_offset_det | (dc_flag_reg & ~sd_active);
      ot_flag_reg <= overtemp_det | (ot_flag_reg & ~sd_active);
    end
  end

  wire [2:0] rate_code = stage_reg[aocfr_pkg::POS_RATE_HI:aocfr_pkg::POS_RATE_LO];
  wire       mono      = stage_reg[aocfr_pkg::POS_BRIDGE];
  wire       use_left  = stage_reg[aocfr_pkg::POS_SOURCE];
  wire [23:0] mono_src = use_left ? left_sample : right_sample;
  wire       halt_next = sd_active | clock_error_det | oc_flag_reg | dc_flag_reg
                         | ot_flag_reg;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rate_reg  <= aocfr_pkg::RATE_X16;
      pct_reg   <= aocfr_pkg::TRIP_PCT_100;
      halt_reg  <= 1'b1;
      a_reg     <= 24'h000000;
      b_reg     <= 24'h000000;
      valid_reg <= 1'b0;
    end else begin
      rate_reg  <= aocfr_pkg::aocfr_rate_mult(rate_code, double_speed_mode);
      pct_reg   <= aocfr_pkg::aocfr_trip_pct(trip_reg);
      halt_reg  <= halt_next;
      valid_reg <= sample_valid & ~halt_next;
      if (sample_valid) begin
        a_reg <= mono ? mono_src : left_sample;
        b_reg <= mono ? mono_src : right_sample;
      end
    end
  end

  assign parallel_bridge_select = mono;
  assign switch_rate_mult       = rate_reg;
  assign analog_gain_sel        = stage_reg[aocfr_pkg::POS_GAIN_HI:aocfr_pkg::POS_GAIN_LO];
  assign overcurrent_trip_level = trip_reg;
  assign trip_level_pct         = pct_reg;
  assign amp_halt               = halt_reg;
  assign amp_a_sample           = a_reg;
  assign amp_b_sample           = b_reg;
  assign amp_sample_valid       = valid_reg;

endmodule : aocfr_top

// ==== verif/aocfr_top_asserts.sv ====
`timescale 1ns/10ps
module aocfr_top_asserts (
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic        double_speed_mode,
  input wire logic [23:0] left_sample,
  input wire logic [23:0] right_sample,
  input wire logic        sample_valid,
  input wire logic        clock_error_det,
  input wire logic        overcurrent_det,
  input wire logic        output_offset_det,
  input wire logic        overtemp_det,
  input wire logic        amp_shutdown_input_n,
  input wire logic        parallel_bridge_select,
  input wire logic [4:0]  switch_rate_mult,
  input wire logic [1:0]  analog_gain_sel,
  input wire logic [1:0]  overcurrent_trip_level,
  input wire logic [6:0]  trip_level_pct,
  input wire logic        amp_halt,
  input wire logic [23:0] amp_a_sample,
  input wire logic [23:0] amp_b_sample,
  input wire logic        amp_sample_valid
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  wire logic any_det = overcurrent_det || output_offset_det || overtemp_det;

  AST_CLK_HALT: assert property (clock_error_det |=> amp_halt)
    else $error("no halt after clock fault");
  // Shutdown is only toggled long after a fault, so the latch must hold meanwhile
  AST_FAULT_HOLD: assert property (any_det |-> ##2 amp_halt [*8])
    else $error("fault latch did not hold halt");
  AST_SD_HALT: assert property (!amp_shutdown_input_n [*5] |=> amp_halt)
    else $error("no halt during shutdown");
  AST_RATE_HALF: assert property ($rose(double_speed_mode) |=>
    switch_rate_mult == ($past(switch_rate_mult) >> 1))
    else $error("rate not halved in double speed");
  AST_TRIP_PCT: assert property (
    trip_level_pct == 7'h64 - 7'h19 * $past(overcurrent_trip_level))
    else $error("trip percentage wrong");
  AST_SMP_VALID: assert property (
    amp_sample_valid == ($past(sample_valid) && !amp_halt))
    else $error("sample valid wrong");
  AST_STEREO: assert property (sample_valid && !parallel_bridge_select |=>
    !amp_sample_valid || (amp_a_sample == $past(left_sample)
    && amp_b_sample == $past(right_sample)))
    else $error("stereo routing wrong");
  AST_GAIN_LEGAL: assert property (analog_gain_sel != 2'h3)
    else $error("reserved gain code reached output");

  cover property ($rose(parallel_bridge_select));
  cover property ($rose(double_speed_mode));
  cover property (any_det ##2 amp_halt);
endmodule : aocfr_top_asserts

bind aocfr_top aocfr_top_asserts chk_u (
  .clk_sys(clk_sys), .arst_n(arst_n), .double_speed_mode(double_speed_mode),
  .left_sample(left_sample), .right_sample(right_sample), .sample_valid(sample_valid),
  .clock_error_det(clock_error_det), .overcurrent_det(overcurrent_det),
  .output_offset_det(output_offset_det), .overtemp_det(overtemp_det),
  .amp_shutdown_input_n(amp_shutdown_input_n),
  .parallel_bridge_select(parallel_bridge_select), .switch_rate_mult(switch_rate_mult),
  .analog_gain_sel(analog_gain_sel), .overcurrent_trip_level(overcurrent_trip_level),
  .trip_level_pct(trip_level_pct), .amp_halt(amp_halt), .amp_a_sample(amp_a_sample),
  .amp_b_sample(amp_b_sample), .amp_sample_valid(amp_sample_valid)
);

// ==== verif/aocfr_host_model.sv ====
`timescale 1ns/10ps
module aocfr_host_model (
  input  wire logic clk_sys,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  // Seven-clock phases keep the pin synchronisers well behind every edge
  localparam int HP = 7;
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick();
    repeat (HP) @(posedge clk_sys);
  endtask : tick
  // Also a repeated start from the clock-low state
  task automatic start();
    sda_low <= 1'b0;
    tick();
    scl <= 1'b1;
    tick();
    sda_low <= 1'b1;
    tick();
    scl <= 1'b0;
    tick();
  endtask : start
  task automatic stop();
    tick();
    sda_low <= 1'b1;
    tick();
    scl <= 1'b1;
    tick();
    sda_low <= 1'b0;
    tick();
  endtask : stop
  // Nine bits: eight of data, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q,
                      output logic ack);
    logic [8:0] tx;
    logic [8:0] rx;
    tx = {d, !mack};
    for (int i = 8; i >= 0; i--) begin
      tick();
      sda_low <= !tx[i];
      tick();
      scl <= 1'b1;
      tick();
      rx[i] = sda_line;
      scl <= 1'b0;
    end
    q   = rx[8:1];
    ack = !rx[0];
  endtask : xfer
endmodule : aocfr_host_model

// ==== verif/tb.sv ====
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb;
  localparam logic [6:0] ADDR    = aocfr_pkg::DEV_ADDR_DEFAULT;
  localparam logic [4:0] RT [8]  = '{5'h06, 5'h08, 5'h0a, 5'h0c, 5'h0e, 5'h10, 5'h14, 5'h18};
  localparam logic [6:0] PCT [4] = '{7'h64, 7'h4b, 7'h32, 7'h19};
  logic        clk_sys;
  logic        arst_n;
  logic        double_speed_mode;
  logic [23:0] left_sample;
  logic [23:0] right_sample;
  logic        sample_valid;
  logic        clock_error_det;
  logic [2:0]  det_v;
  logic        amp_shutdown_input_n;
  logic        scl;
  logic        host_low;
  logic        sda_out;
  logic        sda_oe_n;
  logic        parallel_bridge_select;
  logic [4:0]  switch_rate_mult;
  logic [1:0]  analog_gain_sel;
  logic [1:0]  overcurrent_trip_level;
  logic [6:0]  trip_level_pct;
  logic        amp_halt;
  logic [23:0] amp_a_sample;
  logic [23:0] amp_b_sample;
  logic        amp_sample_valid;
  logic [7:0]  q_x;
  logic        a_x;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          cyc_cnt = 0;
  // Pull-up: SDA is high unless a party pulls it low
  wire logic sda_w = !host_low && (sda_oe_n || sda_out);

  aocfr_top dut_u (
    .clk_sys(clk_sys), .arst_n(arst_n), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .double_speed_mode(double_speed_mode), .left_sample(left_sample),
    .right_sample(right_sample), .sample_valid(sample_valid),
    .clock_error_det(clock_error_det), .overcurrent_det(det_v[2]),
    .output_offset_det(det_v[1]), .overtemp_det(det_v[0]),
    .amp_shutdown_input_n(amp_shutdown_input_n),
    .parallel_bridge_select(parallel_bridge_select), .switch_rate_mult(switch_rate_mult),
    .analog_gain_sel(analog_gain_sel), .overcurrent_trip_level(overcurrent_trip_level),
    .trip_level_pct(trip_level_pct), .amp_halt(amp_halt), .amp_a_sample(amp_a_sample),
    .amp_b_sample(amp_b_sample), .amp_sample_valid(amp_sample_valid));
  aocfr_host_model host_u (.clk_sys(clk_sys), .sda_line(sda_w), .scl(scl), .sda_low(host_low));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  always @(posedge clk_sys) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 60000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic cyc_w(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc_w
  // One data byte per write: pointer auto-increment is not relied on
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    logic [7:0] q;
    logic       a;
    host_u.start();
    host_u.xfer({ADDR, 1'b0}, 1'b0, q, a);
    host_u.xfer(ofs, 1'b0, q, a);
    host_u.xfer(d, 1'b0, q, a);
    host_u.stop();
    `CHK("ack", 1'b1, a)
  endtask : wr
  task automatic rd(input logic [7:0] ofs, input logic [7:0] e);
    logic [7:0] q;
    logic       a;
    host_u.start();
    host_u.xfer({ADDR, 1'b0}, 1'b0, q, a);
    host_u.xfer(ofs, 1'b0, q, a);
    host_u.start();
    host_u.xfer({ADDR, 1'b1}, 1'b0, q, a);
    host_u.xfer(8'hff, 1'b0, q, a);
    host_u.stop();
    `CHK("rdata", e, q)
  endtask : rd
  task automatic smp(input logic [23:0] ea, input logic [23:0] eb);
    left_sample  <= 24'h123456;
    right_sample <= 24'hfedcba;
    sample_valid <= 1'b1;
    @(posedge clk_sys);
    sample_valid <= 1'b0;
    #1;
    `CHK("valid", 1'b1, amp_sample_valid)
    `CHK("side_a", ea, amp_a_sample)
    `CHK("side_b", eb, amp_b_sample)
    @(posedge clk_sys);
  endtask : smp

  initial begin
    {arst_n, double_speed_mode, sample_valid, clock_error_det, det_v} = '0;
    {left_sample, right_sample} = '0;
    amp_shutdown_input_n = 1'b1;
    cyc_w(6);
    arst_n <= 1'b1;
    cyc_w(10);
    rd(8'h06, 8'h51);
    rd(8'h08, 8'h00);
    `CHK("pct", 7'h64, trip_level_pct)
    $display("test reset done");
    for (int c = 0; c < 8; c++) begin
      wr(8'h06, {1'b0, 3'(c), 4'h1});
      cyc_w(4);
      `CHK("rate", RT[c], switch_rate_mult)
      double_speed_mode <= 1'b1;
      cyc_w(4);
      `CHK("rate_half", RT[c] >> 1, switch_rate_mult)
      double_speed_mode <= 1'b0;
    end
    $display("test rate done");
    for (int g = 0; g < 3; g++) begin
      wr(8'h06, {4'hd, 2'(g), 2'b01});
      rd(8'h06, {4'hd, 2'(g), 2'b01});
      `CHK("gain", 2'(g), analog_gain_sel)
      `CHK("bridge", 1'b1, parallel_bridge_select)
    end
    wr(8'h06, 8'h5d);
    rd(8'h06, 8'h59);
    $display("test gain done");
    wr(8'h06, 8'hd3);
    smp(24'h123456, 24'h123456);
    wr(8'h06, 8'hd1);
    smp(24'hfedcba, 24'hfedcba);
    wr(8'h06, 8'h51);
    smp(24'h123456, 24'hfedcba);
    $display("test routing done");
    wr(8'h08, 8'hff);
    rd(8'h08, 8'h30);
    for (int t = 0; t < 4; t++) begin
      wr(8'h08, {2'b00, 2'(t), 4'h0});
      `CHK("trip", 2'(t), overcurrent_trip_level)
      `CHK("pct", PCT[t], trip_level_pct)
    end
    wr(8'h08, 8'h00);
    $display("test trip done");
    clock_error_det <= 1'b1;
    rd(8'h08, 8'h08);
    `CHK("halt", 1'b1, amp_halt)
    clock_error_det <= 1'b0;
    rd(8'h08, 8'h00);
    `CHK("halt", 1'b0, amp_halt)
    for (int k = 0; k < 3; k++) begin
      det_v <= 3'b100 >> k;
      @(posedge clk_sys);
      det_v <= 3'b000;
      rd(8'h08, {5'h00, 3'b100 >> k});
      `CHK("halt", 1'b1, amp_halt)
      amp_shutdown_input_n <= 1'b0;
      cyc_w(12);
      amp_shutdown_input_n <= 1'b1;
      cyc_w(12);
      rd(8'h08, 8'h00);
      `CHK("halt", 1'b0, amp_halt)
    end
    $display("test faults done");
    // Offset 0x07 is never touched; a neighbouring unused offset reads zero
    rd(8'h09, 8'h00);
    host_u.start();
    host_u.xfer({ADDR ^ 7'h01, 1'b0}, 1'b0, q_x, a_x);
    host_u.stop();
    `CHK("nack", 1'b0, a_x)
    $display("test refusals done");
    test_done();
  end
endmodule : tb
